/* include/exec_pkg.sv */
package exec_pkg;
   // datapath widths
   localparam int DATA_W      = 8;
   localparam int PC_W        = 13;
   localparam int LIT_W       = 11;
   localparam int FADDR_W     = 7;
   localparam int FILE_DEPTH  = 128;
   localparam int STACK_DEPTH = 8;
   localparam int SP_W        = 3;
   localparam int LATCH_W     = 5;
   localparam int STATUS_W    = 5;
   localparam int OP_W        = 3;
   localparam int ADDR_W      = 12;
   localparam int APB_W       = 32;
   localparam int WDT_COUNT_W = 8;
   localparam int WDT_PRE_W   = 7;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_INSTR     = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_ACC       = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_STATUS    = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_PC        = 12'h00c;
   localparam logic [ADDR_W-1:0] OFF_LATCH     = 12'h010;
   localparam logic [ADDR_W-1:0] OFF_STACK_TOP = 12'h014;
   localparam logic [ADDR_W-1:0] OFF_WDT       = 12'h018;
   localparam logic [ADDR_W-1:0] OFF_FILE_ADDR = 12'h01c;
   localparam logic [ADDR_W-1:0] OFF_FILE_DATA = 12'h020;

   // instruction word fields
   localparam int OP_LSB    = 0;
   localparam int DEST_BIT  = 3;
   localparam int FADDR_LSB = 8;
   localparam int LIT_LSB   = 16;

   // status bit positions
   localparam int NULL_BIT   = 2;
   localparam int SLEEP_BIT  = 3;
   localparam int EXPIRY_BIT = 4;

   // upper program counter bits taken from the latch
   localparam int LATCH_HI = 4;
   localparam int LATCH_LO = 3;

   // reset values and steps
   localparam logic [STATUS_W-1:0] STATUS_RESET = 5'h18;
   localparam logic [DATA_W-1:0]   DATA_ZERO    = 8'h00;
   localparam logic [DATA_W-1:0]   DATA_ONE     = 8'h01;
   localparam logic [PC_W-1:0]     PC_ZERO      = 13'h0000;
   localparam logic [PC_W-1:0]     PC_STEP      = 13'h0001;
   localparam logic [APB_W-1:0]    WORD_ZERO    = 32'h0000_0000;

   typedef enum logic [OP_W-1:0] {
      OP_NOP       = 3'b000,
      OP_WDT_CLEAR = 3'b001,
      OP_CALL      = 3'b010,
      OP_COMPL     = 3'b011,
      OP_CLR_FILE  = 3'b100,
      OP_CLR_ACC   = 3'b101,
      OP_DEC       = 3'b110,
      OP_DEC_SKIP  = 3'b111
   } op_t;
endpackage : exec_pkg

/* rtl/cpu_exec_clear_dec_call.sv */
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module cpu_exec_clear_dec_call (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [exec_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [exec_pkg::APB_W-1:0]     pwdata,
   output logic [exec_pkg::APB_W-1:0]          prdata,
   output logic                                pready,
   output logic                                pslverr
);
   import exec_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [DATA_W-1:0]      acc_reg;
   logic [DATA_W-1:0]      file_mem [FILE_DEPTH];
   logic [STATUS_W-1:0]    status_reg;
   logic [PC_W-1:0]        pc_reg;
   logic [LATCH_W-1:0]     upper_pc_latch_reg;
   logic [PC_W-1:0]        stack_mem [STACK_DEPTH];
   logic [SP_W-1:0]        sp_reg;
   logic [FADDR_W-1:0]     file_addr_reg;
   logic                   skip_reg;
   logic                   wait_reg;
   logic [WDT_COUNT_W-1:0] wdt_count;
   logic [WDT_PRE_W-1:0]   wdt_prescale;
   logic                   wdt_timeout;

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers
   function automatic op_t op_of(input logic [APB_W-1:0] w);
      op_of = op_t'(w[OP_LSB +: OP_W]);
   endfunction : op_of
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == OFF_INSTR) || (a == OFF_ACC) || (a == OFF_STATUS) ||
               (a == OFF_PC) || (a == OFF_LATCH) || (a == OFF_STACK_TOP) ||
               (a == OFF_WDT) || (a == OFF_FILE_ADDR) || (a == OFF_FILE_DATA);
   endfunction : mapped
   op_t                 op;
   logic                dest;
   logic [FADDR_W-1:0]  faddr;
   logic [LIT_W-1:0]    lit;
   logic [DATA_W-1:0]   operand;
   logic [PC_W-1:0]     stack_top;
   logic [PC_W-1:0]     pc_plus1;
   logic [PC_W-1:0]     call_target;
   assign op          = op_of(pwdata);
   assign dest        = pwdata[DEST_BIT];
   assign faddr       = pwdata[FADDR_LSB +: FADDR_W];
   assign lit         = pwdata[LIT_LSB +: LIT_W];
   assign operand     = file_mem[faddr];
   assign stack_top   = stack_mem[sp_reg];
   assign pc_plus1    = pc_reg + PC_STEP;
   assign call_target = {upper_pc_latch_reg[LATCH_HI:LATCH_LO], lit};

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake
   logic bus_access;
   logic instr_wr;
   logic call_wait;
   logic fire;
   logic wr_fire;
   logic exec;
   logic run;
   logic discard;
   assign bus_access = psel && penable;
   assign instr_wr   = bus_access && pwrite && (paddr == OFF_INSTR);
   // a call holds the access phase one extra cycle
   assign call_wait  = instr_wr && (op == OP_CALL) && !skip_reg && !wait_reg;
   assign pready     = !call_wait;
   assign pslverr    = bus_access && !mapped(paddr);
   assign fire       = bus_access && pready;
   assign wr_fire    = fire && pwrite && mapped(paddr);
   assign exec       = wr_fire && (paddr == OFF_INSTR);
   assign discard    = exec && skip_reg;
   assign run        = exec && !skip_reg;

   // wait marker for the second call cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_reg <= 1'b0;
      end else begin
         wait_reg <= call_wait;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // result steering
   logic [DATA_W-1:0] res;
   logic              to_acc;
   logic              to_file;
   logic              null_upd;
   logic              null_val;
   always_comb begin
      res      = DATA_ZERO;
      to_acc   = 1'b0;
      to_file  = 1'b0;
      null_upd = 1'b0;
      null_val = 1'b0;
      unique case (op)
         OP_COMPL: begin
            res      = ~operand;
            to_acc   = !dest;
            to_file  = dest;
            null_upd = 1'b1;
            null_val = (res == DATA_ZERO);
         end
         OP_DEC, OP_DEC_SKIP: begin
            res      = operand - DATA_ONE;
            to_acc   = !dest;
            to_file  = dest;
            null_upd = (op == OP_DEC);
            null_val = (res == DATA_ZERO);
         end
         OP_CLR_FILE: begin
            to_file  = 1'b1;
            null_upd = 1'b1;
            null_val = 1'b1;
         end
         OP_CLR_ACC: begin
            to_acc   = 1'b1;
            null_upd = 1'b1;
            null_val = 1'b1;
         end
         OP_NOP, OP_WDT_CLEAR, OP_CALL: res = DATA_ZERO;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // accumulator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg <= DATA_ZERO;
      end else if (run && to_acc) begin
         acc_reg <= res;
      end else if (wr_fire && (paddr == OFF_ACC)) begin
         acc_reg <= pwdata[DATA_W-1:0];
      end
   end

   // operand file; bus port goes through the address register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < FILE_DEPTH; i++) begin
            file_mem[i] <= DATA_ZERO;
         end
      end else if (run && to_file) begin
         file_mem[faddr] <= res;
      end else if (wr_fire && (paddr == OFF_FILE_DATA)) begin
         file_mem[file_addr_reg] <= pwdata[DATA_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         file_addr_reg <= '0;
      end else if (wr_fire && (paddr == OFF_FILE_ADDR)) begin
         file_addr_reg <= pwdata[FADDR_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status: clear beats a same-cycle timeout; null bit apart so no update is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= STATUS_RESET;
      end else begin
         if (run && (op == OP_WDT_CLEAR)) begin
            status_reg[EXPIRY_BIT] <= 1'b1;
            status_reg[SLEEP_BIT]  <= 1'b1;
         end else if (wdt_timeout) begin
            status_reg[EXPIRY_BIT] <= 1'b0;
         end
         if (run && null_upd) begin
            status_reg[NULL_BIT] <= null_val;
         end else if (wr_fire && (paddr == OFF_STATUS)) begin
            status_reg[NULL_BIT] <= pwdata[NULL_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program counter and return stack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_reg <= PC_ZERO;
      end else if (run && (op == OP_CALL)) begin
         pc_reg <= call_target;
      end else if (exec) begin
         pc_reg <= pc_plus1;
      end else if (wr_fire && (paddr == OFF_PC)) begin
         pc_reg <= pwdata[PC_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upper_pc_latch_reg <= '0;
      end else if (wr_fire && (paddr == OFF_LATCH)) begin
         upper_pc_latch_reg <= pwdata[LATCH_W-1:0];
      end
   end

   // circular stack: a ninth push overwrites the oldest entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_reg <= '0;
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_mem[i] <= PC_ZERO;
         end
      end else if (run && (op == OP_CALL)) begin
         sp_reg                      <= sp_reg + SP_W'(1);
         stack_mem[sp_reg + SP_W'(1)] <= pc_plus1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // skip: zero result turns the next instruction into a nop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         skip_reg <= 1'b0;
      end else if (run && (op == OP_DEC_SKIP)) begin
         skip_reg <= (res == DATA_ZERO);
      end else if (discard) begin
         skip_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // watchdog
   watchdog_timer #(
      .PRE_W   (WDT_PRE_W),
      .COUNT_W (WDT_COUNT_W)
   ) u_wdt (
      .pclk     (pclk),
      .presetn  (presetn),
      .clear    (run && (op == OP_WDT_CLEAR)),
      .count    (wdt_count),
      .prescale (wdt_prescale),
      .timeout  (wdt_timeout)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read data, latched in the setup cycle so it stands through access
   logic [APB_W-1:0] rd_next;
   always_comb begin
      rd_next = WORD_ZERO;
      unique case (paddr)
         OFF_ACC:       rd_next[DATA_W-1:0]      = acc_reg;
         OFF_STATUS:    rd_next[STATUS_W-1:0]    = status_reg;
         OFF_PC:        rd_next[PC_W-1:0]        = pc_reg;
         OFF_LATCH:     rd_next[LATCH_W-1:0]     = upper_pc_latch_reg;
         OFF_STACK_TOP: rd_next[PC_W-1:0]        = stack_top;
         OFF_WDT:       rd_next[WDT_COUNT_W-1:0] = wdt_count;
         OFF_FILE_ADDR: rd_next[FADDR_W-1:0]     = file_addr_reg;
         OFF_FILE_DATA: rd_next[DATA_W-1:0]      = file_mem[file_addr_reg];
         default:       rd_next                  = WORD_ZERO;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= WORD_ZERO;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   wdt_count_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      run && (op == OP_WDT_CLEAR) |=> (wdt_count == '0) && (wdt_prescale == '0))
      else $error("watchdog count not cleared");
   wdt_pre_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      run && (op == OP_WDT_CLEAR) ##1 !(run && (op == OP_WDT_CLEAR))
      |=> (wdt_prescale == WDT_PRE_W'(1)))
      else $error("prescaler did not restart from zero");
   wdt_status_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      run && (op == OP_WDT_CLEAR) |=> status_reg[EXPIRY_BIT] && status_reg[SLEEP_BIT]
      && (status_reg[NULL_BIT] == $past(status_reg[NULL_BIT])))
      else $error("watchdog clear status wrong");
   call_push_a: assert property (@(posedge pclk) disable iff (!presetn)
      run && (op == OP_CALL) |=> (stack_top == $past(pc_plus1))
      && (sp_reg == $past(sp_reg) + SP_W'(1)))
      else $error("call return address not pushed");
   call_target_a: assert property (@(posedge pclk) disable iff (!presetn)
      run && (op == OP_CALL) |=> (pc_reg == $past(call_target)))
      else $error("call target wrong");
   call_two_cyc_a: assert property (@(posedge pclk) disable iff (!presetn)
      call_wait |-> !pready ##1 (pready && $stable(status_reg)) ##1 $stable(status_reg))
      else $error("call not two cycles or status changed");
   dest_select_a: assert property (@(posedge pclk) disable iff (!presetn)
      run && (op inside {OP_COMPL, OP_DEC, OP_DEC_SKIP}) && !dest
      |=> (acc_reg == $past(res)) && (file_mem[$past(faddr)] == $past(operand)))
      else $error("result went to wrong destination");
   compl_file_a: assert property (@(posedge pclk) disable iff (!presetn)
      run && (op == OP_COMPL) && dest |=> (file_mem[$past(faddr)] == ~$past(operand)))
      else $error("complement result wrong");
   clr_file_a: assert property (@(posedge pclk) disable iff (!presetn)
      run && (op == OP_CLR_FILE) |=> (file_mem[$past(faddr)] == DATA_ZERO)
      && status_reg[NULL_BIT])
      else $error("clear file wrong");
   clr_acc_a: assert property (@(posedge pclk) disable iff (!presetn)
      run && (op == OP_CLR_ACC) |=> (acc_reg == DATA_ZERO) && status_reg[NULL_BIT])
      else $error("clear accumulator wrong");
   dec_value_a: assert property (@(posedge pclk) disable iff (!presetn)
      run && (op == OP_DEC) && dest
      |=> (file_mem[$past(faddr)] == $past(operand) - DATA_ONE))
      else $error("decrement result wrong");
   skip_nonzero_a: assert property (@(posedge pclk) disable iff (!presetn)
      run && (op == OP_DEC_SKIP) && (res != DATA_ZERO) |=> !skip_reg)
      else $error("nonzero result caused a skip");
   skip_discard_a: assert property (@(posedge pclk) disable iff (!presetn)
      discard |=> $stable(acc_reg) && (pc_reg == $past(pc_plus1)) && !skip_reg)
      else $error("skipped instruction not discarded");
   null_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      run && (op inside {OP_COMPL, OP_DEC, OP_DEC_SKIP})
      |=> (status_reg[NULL_BIT] == (($past(op) == OP_DEC_SKIP) ?
          $past(status_reg[NULL_BIT]) : ($past(res) == DATA_ZERO))))
      else $error("null flag wrong");
endmodule : cpu_exec_clear_dec_call

/* rtl/watchdog_timer.sv */
`timescale 1ns/1ps
module watchdog_timer #(
   parameter int PRE_W   = exec_pkg::WDT_PRE_W,
   parameter int COUNT_W = exec_pkg::WDT_COUNT_W
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               clear,
   output logic [COUNT_W-1:0]      count,
   output logic [PRE_W-1:0]        prescale,
   output logic                    timeout
);
   import exec_pkg::*;

   localparam logic [PRE_W-1:0]   PRE_ONE   = PRE_W'(1);
   localparam logic [PRE_W-1:0]   PRE_MAX   = {PRE_W{1'b1}};
   localparam logic [COUNT_W-1:0] COUNT_ONE = COUNT_W'(1);
   localparam logic [COUNT_W-1:0] COUNT_MAX = {COUNT_W{1'b1}};

   logic tick;

   assign tick = (prescale == PRE_MAX);

   // prescaler: clear restarts the full period, not just the counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= '0;
      end else if (clear) begin
         prescale <= '0;
      end else begin
         prescale <= prescale + PRE_ONE;
      end
   end

   // main count advances once per prescaler wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
      end else if (clear) begin
         count <= '0;
      end else if (tick) begin
         count <= count + COUNT_ONE;
      end
   end

   // one-cycle pulse on wrap of the main count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout <= 1'b0;
      end else begin
         timeout <= !clear && tick && (count == COUNT_MAX);
      end
   end
endmodule : watchdog_timer

/* test/cpu_exec_clear_dec_call_bench.sv */
`timescale 1ns/1ps
module cpu_exec_clear_dec_call_bench;
   import exec_pkg::*;
   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [APB_W-1:0]  pwdata;
   logic [APB_W-1:0]  prdata;
   logic              pready;
   logic              pslverr;
   int                errors;
   int                num_checks;
   int                waits;
   logic              err;
   logic [APB_W-1:0]  rd;
   logic [APB_W-1:0]  keep;
   logic [7:0]        v;
   logic [7:0]        acc;
   logic [7:0]        res;
   logic [6:0]        fa;
   logic [4:0]        lat;
   logic [10:0]       lit;
   logic [12:0]       pc;
   logic              d;
   logic              nul;
   op_t               op;

   cpu_exec_clear_dec_call DUT (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr)
   );

   always #20 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input logic [APB_W-1:0] seen, input logic [APB_W-1:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one transfer, entered just after a rising edge; pready is read in the
   // low half so the value stands settled for the closing edge
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [APB_W-1:0] wd);
      logic done;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      waits = 0;
      do begin
         @(negedge pclk);
         done = pready;
         rd   = prdata;
         err  = pslverr;
         @(posedge pclk);
         if (done !== 1'b1) waits++;
      end while (done !== 1'b1 && waits < 20);
      if (done !== 1'b1) begin
         errors++;
         end_of_test();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [APB_W-1:0] exp);
      apb(1'b0, a, WORD_ZERO);
      check(rd, exp);
   endtask : rdc

   // instruction word: op, dest, file address, literal
   task automatic exec(input op_t o, input logic dd, input logic [6:0] f, input logic [10:0] l);
      apb(1'b1, OFF_INSTR, {5'h00, l, 1'b0, f, 4'h0, dd, o});
   endtask : exec

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      errors = 0;
      num_checks = 0;
      void'($urandom(96));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(OFF_STATUS, 32'h0000_0018);
      // let the prescaler run mid-count before the clear
      repeat (300) @(posedge pclk);
      apb(1'b1, OFF_STATUS, 32'h0000_0004);
      exec(OP_WDT_CLEAR, 1'b0, 7'h00, 11'h000);
      rdc(OFF_STATUS, 32'h0000_001c);
      rdc(OFF_WDT, WORD_ZERO);
      repeat (100) @(posedge pclk);
      rdc(OFF_WDT, WORD_ZERO);
      // calls: top corner then random
      for (int i = 0; i < 3; i++) begin
         lat = (i == 0) ? 5'h18 : 5'($urandom);
         lit = (i == 0) ? 11'h7ff : 11'($urandom);
         pc  = 13'($urandom);
         apb(1'b1, OFF_LATCH, APB_W'(lat));
         apb(1'b1, OFF_PC, APB_W'(pc));
         apb(1'b0, OFF_STATUS, WORD_ZERO);
         keep = rd;
         exec(OP_CALL, 1'b0, 7'h00, lit);
         check(APB_W'(waits), 32'h0000_0001);
         rdc(OFF_PC, APB_W'({lat[4:3], lit}));
         rdc(OFF_STACK_TOP, APB_W'(pc + PC_STEP));
         rdc(OFF_STATUS, keep);
      end
      // random operands with zero, one and all-ones corners
      for (int i = 0; i < 30; i++) begin
         op  = (i % 3 == 0) ? OP_COMPL : (i % 3 == 1) ? OP_DEC : OP_DEC_SKIP;
         d   = ((i / 3) % 2) == 1;
         fa  = (i == 5) ? 7'h7f : 7'($urandom);
         v   = (i < 6) ? 8'h00 : (i < 12) ? 8'h01 : (i < 18) ? 8'hff : 8'($urandom);
         if (op == OP_DEC_SKIP && v == 8'h01) v = 8'h02;
         acc = 8'($urandom);
         nul = 1'($urandom);
         apb(1'b1, OFF_FILE_ADDR, APB_W'(fa));
         apb(1'b1, OFF_FILE_DATA, APB_W'(v));
         apb(1'b1, OFF_ACC, APB_W'(acc));
         apb(1'b1, OFF_STATUS, APB_W'(nul) << NULL_BIT);
         exec(op, d, fa, 11'h000);
         res = (op == OP_COMPL) ? ~v : v - DATA_ONE;
         rdc(OFF_ACC, APB_W'(d ? acc : res));
         rdc(OFF_FILE_DATA, APB_W'(d ? res : v));
         apb(1'b0, OFF_STATUS, WORD_ZERO);
         check(APB_W'(rd[NULL_BIT]), APB_W'(op == OP_DEC_SKIP ? nul : res == 8'h00));
      end
      // zero result discards the next instruction
      fa = 7'h7f;
      apb(1'b1, OFF_FILE_ADDR, APB_W'(fa));
      apb(1'b1, OFF_FILE_DATA, 32'h0000_0001);
      apb(1'b1, OFF_ACC, 32'h0000_0055);
      apb(1'b1, OFF_STATUS, WORD_ZERO);
      apb(1'b1, OFF_PC, 32'h0000_0100);
      exec(OP_DEC_SKIP, 1'b1, fa, 11'h000);
      exec(OP_CLR_ACC, 1'b0, 7'h00, 11'h000);
      rdc(OFF_ACC, 32'h0000_0055);
      rdc(OFF_PC, 32'h0000_0102);
      rdc(OFF_STATUS, 32'h0000_0018);
      rdc(OFF_FILE_DATA, WORD_ZERO);
      exec(OP_CLR_ACC, 1'b0, 7'h00, 11'h000);
      rdc(OFF_ACC, WORD_ZERO);
      rdc(OFF_STATUS, 32'h0000_001c);
      // nonzero result lets the next one run
      apb(1'b1, OFF_FILE_DATA, 32'h0000_0002);
      apb(1'b1, OFF_STATUS, WORD_ZERO);
      exec(OP_DEC_SKIP, 1'b0, fa, 11'h000);
      exec(OP_CLR_FILE, 1'b0, fa, 11'h000);
      rdc(OFF_ACC, 32'h0000_0001);
      rdc(OFF_FILE_DATA, WORD_ZERO);
      rdc(OFF_STATUS, 32'h0000_001c);
      // a plain nop only advances the program counter
      exec(OP_NOP, 1'b0, fa, 11'h000);
      rdc(OFF_PC, 32'h0000_0106);
      // a call in the discard slot neither waits, pushes nor jumps
      apb(1'b0, OFF_STACK_TOP, WORD_ZERO);
      keep = rd;
      apb(1'b1, OFF_FILE_DATA, 32'h0000_0001);
      exec(OP_DEC_SKIP, 1'b1, fa, 11'h000);
      exec(OP_CALL, 1'b0, 7'h00, 11'h123);
      check(APB_W'(waits), WORD_ZERO);
      rdc(OFF_PC, 32'h0000_0108);
      rdc(OFF_STACK_TOP, keep);
      // unmapped address answers with an error and zero data
      apb(1'b0, 12'h024, WORD_ZERO);
      check(APB_W'(err), 32'h0000_0001);
      check(rd, WORD_ZERO);
      end_of_test();
   end
endmodule : cpu_exec_clear_dec_call_bench
